/* hw/mode_guard.v */
// Purpose: CPU mode tracker and segmentation/security register guard
// Assumes: Core events arrive on pclk; APB accesses come from the CPU
// Notes: Permission follows the mode held here at the access edge
`timescale 1ns/1ps
`default_nettype none
`include "mode_guard_consts.vh"
module mode_guard #(
  parameter STACK_DEPTH = 8,
  parameter STACK_AW = 3,
  parameter [15:0] SYSTEM_CALL_VECTOR = 16'h0100,
  parameter [15:0] FIRMWARE_CALL_VECTOR = 16'h0200,
  parameter [15:0] SPECIAL_SYSTEM_ADDR = 16'h0300,
  parameter [15:0] SPECIAL_USER_ADDR = 16'h0304,
  parameter [31:0] PARTITION = 32'h0000_0000
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Core events
  input wire call_valid,
  input wire [1:0] call_kind,
  input wire [15:0] call_target,
  input wire exc_entry,
  input wire reti,
  // Guard outputs
  output reg [2:0] cpu_mode,
  output reg [31:0] seg_table_base,
  output reg [7:0] seg_ctrl,
  output reg nvm_limit_en,
  output reg coprocessor_ram_limit_en,
  output reg aes_en,
  output reg pk_en,
  output reg [31:0] partition
);

  // Address decode, used for reads and writes
  function [2:0] reg_index;
    input [7:0] addr;
    begin
      case (addr)
        `ADDR_MODE: reg_index = `REG_MODE;
        `ADDR_SEG_BASE: reg_index = `REG_SEG_BASE;
        `ADDR_SEG_CTRL: reg_index = `REG_SEG_CTRL;
        `ADDR_FEAT_TEMP: reg_index = `REG_FEAT_TEMP;
        `ADDR_FEAT_PERM: reg_index = `REG_FEAT_PERM;
        `ADDR_PARTITION: reg_index = `REG_PARTITION;
        `ADDR_STATUS: reg_index = `REG_STATUS;
        default: reg_index = `REG_NONE;
      endcase
    end
  endfunction

  // Write permission per mode and register
  function can_write;
    input [2:0] mode;
    input [2:0] idx;
    begin
      case (idx)
        `REG_SEG_BASE, `REG_SEG_CTRL: can_write = (mode == `MODE_SYSTEM);
        `REG_MODE: can_write = (mode == `MODE_SYSTEM) || (mode == `MODE_BOOT) ||
          (mode == `MODE_TEST);
        `REG_FEAT_TEMP, `REG_FEAT_PERM: can_write = (mode == `MODE_SYSTEM) ||
          (mode == `MODE_BOOT) || (mode == `MODE_TEST);
        `REG_STATUS: can_write = (mode != `MODE_USER);
        default: can_write = 1'b0; // Partition is never writable
      endcase
    end
  endfunction

  // Read permission per mode and register
  function can_read;
    input [2:0] mode;
    input [2:0] idx;
    begin
      case (idx)
        `REG_SEG_BASE, `REG_SEG_CTRL: can_read = (mode == `MODE_SYSTEM);
        `REG_NONE: can_read = 1'b0;
        default: can_read = 1'b1;
      endcase
    end
  endfunction

  // Mode target of a call, {hit, mode}
  function [3:0] call_mode;
    input [1:0] kind;
    input [15:0] target;
    reg special;
    begin
      special = (kind == `CALL_LONG) || (kind == `CALL_ABS) || (kind == `CALL_EXT);
      if (target == SYSTEM_CALL_VECTOR) begin
        call_mode = {1'b1, `MODE_SYSTEM};
      end else if (target == FIRMWARE_CALL_VECTOR) begin
        call_mode = {1'b1, `MODE_FIRMWARE};
      end else if (special && target == SPECIAL_SYSTEM_ADDR) begin
        call_mode = {1'b1, `MODE_SYSTEM};
      end else if (special && target == SPECIAL_USER_ADDR) begin
        call_mode = {1'b1, `MODE_USER};
      end else begin
        call_mode = {1'b0, `MODE_RST};
      end
    end
  endfunction

  function valid_mode;
    input [2:0] m;
    begin
      valid_mode = (m <= `MODE_USER);
    end
  endfunction

  reg [3:0] feat_temp;
  reg [7:0] feat_perm;
  reg denied;
  reg stack_fault;
  wire stack_empty;
  wire stack_full;
  wire [2:0] stack_top;

  wire [2:0] idx = reg_index(paddr);
  wire access = psel && penable && pready;
  wire wr_ok = can_write(cpu_mode, idx);
  wire rd_ok = can_read(cpu_mode, idx);
  wire do_write = access && pwrite && wr_ok;
  wire [3:0] call_hit = call_mode(call_kind, call_target);
  wire call_switch = call_valid && call_hit[3];
  wire csr_mode_ok = valid_mode(pwdata[`MODE_MSB:`MODE_LSB]);
  wire csr_write = do_write && idx == `REG_MODE && csr_mode_ok;
  wire mode_event = exc_entry || reti || call_switch;
  wire bad_value = access && pwrite && wr_ok && idx == `REG_MODE && !csr_mode_ok;
  wire refused = access && ((pwrite && !wr_ok) || (!pwrite && !rd_ok) || bad_value);
  wire push = exc_entry && !stack_full;
  wire pop = reti && !exc_entry && !stack_empty;

  // Permanent lock wins over temporary setting per feature
  wire [3:0] perm_lock = feat_perm[`PERM_LOCK_MSB:`PERM_LOCK_LSB];
  wire [3:0] perm_val = feat_perm[`PERM_VAL_MSB:`PERM_VAL_LSB];
  wire [3:0] feat_eff = (perm_lock & perm_val) | (~perm_lock & feat_temp);
  wire [3:0] next_lock = perm_lock | pwdata[`PERM_LOCK_MSB:`PERM_LOCK_LSB];
  wire [3:0] next_val = (perm_lock & perm_val) |
    (~perm_lock & pwdata[`PERM_VAL_MSB:`PERM_VAL_LSB]);

  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0000_0000;
    case (idx)
      `REG_MODE: next_rdata[`MODE_MSB:`MODE_LSB] = cpu_mode;
      `REG_SEG_BASE: next_rdata = seg_table_base;
      `REG_SEG_CTRL: next_rdata[7:0] = seg_ctrl;
      `REG_FEAT_TEMP: next_rdata[`FEAT_MSB:0] = feat_temp;
      `REG_FEAT_PERM: next_rdata[7:0] = feat_perm;
      `REG_PARTITION: next_rdata = partition;
      `REG_STATUS: begin
        next_rdata[`ST_DENIED] = denied;
        next_rdata[`ST_STACK_FAULT] = stack_fault;
        next_rdata[`ST_MODE_MSB:`ST_MODE_LSB] = cpu_mode;
        next_rdata[`ST_FEAT_MSB:`ST_FEAT_LSB] = feat_eff;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= (pwrite && !wr_ok) || (!pwrite && !rd_ok) ||
        (pwrite && wr_ok && idx == `REG_MODE && !csr_mode_ok);
      prdata <= (!pwrite && rd_ok) ? next_rdata : 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // Mode tracking; core events beat a same-cycle mode register write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_mode <= `MODE_RST;
    end else if (exc_entry) begin
      cpu_mode <= `MODE_SYSTEM;
    end else if (reti) begin
      cpu_mode <= stack_empty ? cpu_mode : stack_top;
    end else if (call_switch) begin
      cpu_mode <= call_hit[2:0];
    end else if (csr_write && !mode_event) begin
      cpu_mode <= pwdata[`MODE_MSB:`MODE_LSB];
    end
  end

  // Saved modes for nested handlers
  mode_stack #(
    .DEPTH(STACK_DEPTH),
    .AW(STACK_AW)
  ) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(push),
    .pop(pop),
    .push_data(cpu_mode),
    .top(stack_top),
    .empty(stack_empty),
    .full(stack_full)
  );

  // Security attribute registers; resets are constants only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_table_base <= `SEG_BASE_RST;
      seg_ctrl <= `SEG_CTRL_RST;
      feat_temp <= `FEAT_TEMP_RST;
      feat_perm <= `FEAT_PERM_RST;
    end else if (do_write) begin
      // Writes without write permission never reach here
      case (idx)
        `REG_SEG_BASE: seg_table_base <= pwdata;
        `REG_SEG_CTRL: seg_ctrl <= pwdata[7:0];
        `REG_FEAT_TEMP: feat_temp <= pwdata[`FEAT_MSB:0];
        `REG_FEAT_PERM: begin
          // Lock bits only set; locked values frozen until reset
          feat_perm[`PERM_LOCK_MSB:`PERM_LOCK_LSB] <= next_lock;
          feat_perm[`PERM_VAL_MSB:`PERM_VAL_LSB] <= next_val;
        end
        default: feat_perm <= feat_perm;
      endcase
    end
  end

  // Sticky flags, write one to clear; a new event wins over the clear
  wire clr = do_write && idx == `REG_STATUS;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      denied <= 1'b0;
      stack_fault <= 1'b0;
    end else begin
      denied <= refused | (denied & ~(clr & pwdata[`ST_DENIED]));
      stack_fault <= (exc_entry & stack_full) | (reti & !exc_entry & stack_empty) |
        (stack_fault & ~(clr & pwdata[`ST_STACK_FAULT]));
    end
  end

  // Registered outputs; table memory itself is left to the segment rights
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_limit_en <= 1'b1;
      coprocessor_ram_limit_en <= 1'b1;
      aes_en <= 1'b0;
      pk_en <= 1'b0;
      partition <= 32'h0000_0000;
    end else begin
      nvm_limit_en <= feat_eff[0];
      coprocessor_ram_limit_en <= feat_eff[1];
      aes_en <= feat_eff[2];
      pk_en <= feat_eff[3];
      partition <= PARTITION; // Build-time constant
    end
  end

endmodule
`default_nettype wire

/* shared/mode_guard_consts.vh */
// Purpose: Shared constants of the CPU mode and segmentation guard
// Assumes: APB byte addresses, 32-bit data
// Notes: Definitions only
`ifndef MODE_GUARD_CONSTS_VH
`define MODE_GUARD_CONSTS_VH

// CPU mode codes
`define MODE_BOOT 3'h0
`define MODE_TEST 3'h1
`define MODE_FIRMWARE 3'h2
`define MODE_SYSTEM 3'h3
`define MODE_USER 3'h4
`define MODE_RST `MODE_BOOT

// Register byte offsets
`define ADDR_MODE 8'h00
`define ADDR_SEG_BASE 8'h04
`define ADDR_SEG_CTRL 8'h08
`define ADDR_FEAT_TEMP 8'h0C
`define ADDR_FEAT_PERM 8'h10
`define ADDR_PARTITION 8'h14
`define ADDR_STATUS 8'h18

// Register indexes for the permission functions
`define REG_MODE 3'h0
`define REG_SEG_BASE 3'h1
`define REG_SEG_CTRL 3'h2
`define REG_FEAT_TEMP 3'h3
`define REG_FEAT_PERM 3'h4
`define REG_PARTITION 3'h5
`define REG_STATUS 3'h6
`define REG_NONE 3'h7

// Reset values, restrictive
`define SEG_BASE_RST 32'h0000_0000
`define SEG_CTRL_RST 8'h00
`define FEAT_TEMP_RST 4'h3
`define FEAT_PERM_RST 8'h00

// Field positions
`define MODE_LSB 0
`define MODE_MSB 2
`define FEAT_MSB 3
`define PERM_VAL_LSB 0
`define PERM_VAL_MSB 3
`define PERM_LOCK_LSB 4
`define PERM_LOCK_MSB 7
`define ST_DENIED 0
`define ST_STACK_FAULT 1
`define ST_MODE_LSB 4
`define ST_MODE_MSB 6
`define ST_FEAT_LSB 8
`define ST_FEAT_MSB 11

// Call kinds
`define CALL_LONG 2'h0
`define CALL_ABS 2'h1
`define CALL_EXT 2'h2
`define CALL_PLAIN 2'h3

`endif

/* hw/mode_stack.v */
// Purpose: Small memory saving the CPU mode across nested exceptions
// Assumes: Push and pop never in the same cycle
// Notes: Top of stack comes out of a register
`timescale 1ns/1ps
`default_nettype none
`include "mode_guard_consts.vh"
module mode_stack #(
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Stack control
  input wire push,
  input wire pop,
  input wire [2:0] push_data,
  // Stack state
  output reg [2:0] top,
  output reg empty,
  output reg full
);
  reg [2:0] mem [0:DEPTH-1];
  reg [AW:0] count;
  wire [AW-1:0] wr_idx = count[AW-1:0];
  wire [AW-1:0] below_idx = count[AW-1:0] - {{(AW-1){1'b0}}, 1'b1} - {{(AW-1){1'b0}}, 1'b1};

  always @(posedge pclk) begin
    if (push && !full) begin
      mem[wr_idx] <= push_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {(AW+1){1'b0}};
      top <= `MODE_RST;
      empty <= 1'b1;
      full <= 1'b0;
    end else if (push && !full) begin
      count <= count + {{AW{1'b0}}, 1'b1};
      top <= push_data;
      empty <= 1'b0;
      full <= (count == DEPTH - 1);
    end else if (pop && !empty) begin
      count <= count - {{AW{1'b0}}, 1'b1};
      // Next top read from memory, registered
      top <= (count > 1) ? mem[below_idx] : `MODE_RST;
      empty <= (count == 1);
      full <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* testbench/mode_guard_props.sv */
// Purpose: Port assertions for the mode guard
// Assumes: One pclk domain, presetn async low
// Notes: Bound into every mode_guard
`timescale 1ns/1ps
`default_nettype none
`include "mode_guard_consts.vh"
module mode_guard_props #(
  parameter [15:0] SYSTEM_CALL_VECTOR = 16'h0100,
  parameter [15:0] SPECIAL_USER_ADDR = 16'h0304,
  parameter [31:0] PARTITION = 32'h0000_0000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core events
  input wire logic call_valid,
  input wire logic [1:0] call_kind,
  input wire logic [15:0] call_target,
  input wire logic exc_entry,
  input wire logic reti,
  // Guard state
  input wire logic [2:0] cpu_mode,
  input wire logic [31:0] seg_table_base,
  input wire logic [7:0] seg_ctrl,
  input wire logic [31:0] partition
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire done = psel & penable & pready;
  // Only calls with no exception or return beside them decide the mode
  wire quiet = !exc_entry && !reti;
  wire [2:0] wmode = pwdata[2:0];
  wire seg_hit = paddr == `ADDR_SEG_BASE || paddr == `ADDR_SEG_CTRL;
  reset_clear_a: assert property ($rose(presetn) |-> seg_table_base == `SEG_BASE_RST
    && cpu_mode == `MODE_RST) else $error("reset state not restrictive");
  user_block_a: assert property (done && cpu_mode == `MODE_USER && seg_hit |-> pslverr)
    else $error("user reached segment register");
  seg_keep_a: assert property (done && pwrite && cpu_mode != `MODE_SYSTEM && seg_hit
    |=> $stable(seg_table_base) && $stable(seg_ctrl)) else $error("segment write leaked");
  seg_write_a: assert property (done && pwrite && cpu_mode == `MODE_SYSTEM
    && paddr == `ADDR_SEG_BASE |=> seg_table_base == $past(pwdata)) else $error("base lost");
  mode_write_a: assert property (done && pwrite && paddr == `ADDR_MODE && !pslverr
    && quiet && !call_valid |=> cpu_mode == $past(wmode)) else $error("mode write lost");
  exc_mode_a: assert property (exc_entry |=> cpu_mode == `MODE_SYSTEM)
    else $error("exception kept mode");
  sys_call_a: assert property (call_valid && quiet && call_target == SYSTEM_CALL_VECTOR
    |=> cpu_mode == `MODE_SYSTEM) else $error("system vector ignored");
  special_call_a: assert property (call_valid && quiet && call_kind != `CALL_PLAIN
    && call_target == SPECIAL_USER_ADDR |=> cpu_mode == `MODE_USER) else $error("no switch");
  part_fixed_a: assert property ($past(presetn) |-> partition == PARTITION)
    else $error("partition moved");
  denied_quiet_a: assert property (done && pwrite && pslverr |=> $stable(seg_table_base)
    && $stable(seg_ctrl)) else $error("denied write changed state");
endmodule
bind mode_guard mode_guard_props #(
  .SYSTEM_CALL_VECTOR(SYSTEM_CALL_VECTOR),
  .SPECIAL_USER_ADDR(SPECIAL_USER_ADDR),
  .PARTITION(PARTITION)
) props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .call_valid, .call_kind, .call_target, .exc_entry, .reti, .cpu_mode, .seg_table_base,
  .seg_ctrl, .partition);
`default_nettype wire

/* testbench/mode_guard_bench.sv */
// Purpose: Self-checking bench for the mode guard
// Assumes: APB master in tasks, core events pulsed
// Notes: Reads right after a commit edge see old state, so waits precede output checks
`timescale 1ns/1ps
`default_nettype none
`include "mode_guard_consts.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("FAIL at %0t: got %h expected %h", $time, a, b); end end
module mode_guard_bench;
  localparam logic [15:0] sys_vec = 16'h0140;
  localparam logic [15:0] fw_vec = 16'h0240;
  localparam logic [15:0] spec_sys = 16'h0330;
  localparam logic [15:0] spec_user = 16'h0334;
  localparam logic [31:0] part_val = 32'h0000_00a5;
  logic pclk, presetn, psel, penable, pwrite, call_valid, exc_entry, reti;
  logic pready, pslverr, nvm_limit_en, coprocessor_ram_limit_en, aes_en, pk_en, de;
  logic [7:0] paddr, seg_ctrl;
  logic [31:0] pwdata, prdata, seg_table_base, partition, dr;
  logic [1:0] call_kind;
  logic [15:0] call_target;
  logic [2:0] cpu_mode;
  int fail_count = 0;
  int check_count = 0;
  mode_guard #(.SYSTEM_CALL_VECTOR(sys_vec), .FIRMWARE_CALL_VECTOR(fw_vec),
    .SPECIAL_SYSTEM_ADDR(spec_sys), .SPECIAL_USER_ADDR(spec_user), .PARTITION(part_val))
    DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .call_valid, .call_kind, .call_target, .exc_entry, .reti, .cpu_mode,
    .seg_table_base, .seg_ctrl, .nvm_limit_en, .coprocessor_ram_limit_en, .aes_en, .pk_en,
    .partition);
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  task report_and_stop;
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
    logic [31:0] r;
    logic e;
    apb(a, 1, d, r, e);
    `CHK(e, x)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(a, 0, 32'h0000_0000, r, e);
    `CHK(e, xe)
    `CHK(r, x)
  endtask
  task automatic ev(input logic e, input logic q, input logic [1:0] k, input logic [15:0] t,
    input logic [2:0] m);
    @(posedge pclk);
    exc_entry <= e;
    reti <= q;
    call_valid <= !e && !q;
    call_kind <= k;
    call_target <= t;
    @(posedge pclk);
    exc_entry <= 0;
    reti <= 0;
    call_valid <= 0;
    @(posedge pclk);
    `CHK(cpu_mode, m)
  endtask
  task automatic do_reset;
    presetn <= 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
  endtask
  initial begin
    {psel, penable, pwrite, call_valid, exc_entry, reti, presetn} = 0;
    paddr = 0;
    pwdata = 0;
    call_kind = 0;
    call_target = 0;
    do_reset;
    `CHK(seg_table_base, `SEG_BASE_RST)
    `CHK(cpu_mode, `MODE_RST)
    rd(`ADDR_FEAT_TEMP, 32'h0000_0003, 0);
    wr(`ADDR_PARTITION, 32'h0000_ffff, 1);
    rd(`ADDR_PARTITION, part_val, 0);
    wr(`ADDR_SEG_BASE, 32'h1234_5678, 1);
    rd(`ADDR_SEG_BASE, 32'h0000_0000, 1);
    `CHK(seg_table_base, 32'h0000_0000)
    wr(`ADDR_MODE, `MODE_SYSTEM, 0);
    wr(`ADDR_SEG_BASE, 32'h1234_5678, 0);
    rd(`ADDR_SEG_BASE, 32'h1234_5678, 0);
    wr(`ADDR_SEG_CTRL, 32'h0000_005a, 0);
    rd(`ADDR_SEG_CTRL, 32'h0000_005a, 0);
    wr(`ADDR_MODE, 32'h0000_0005, 1);
    wr(`ADDR_MODE, `MODE_USER, 0);
    wr(`ADDR_SEG_BASE, 32'h0000_0000, 1);
    rd(`ADDR_SEG_CTRL, 32'h0000_0000, 1);
    wr(`ADDR_MODE, `MODE_SYSTEM, 1);
    @(posedge pclk);
    `CHK(cpu_mode, `MODE_USER)
    `CHK(seg_table_base, 32'h1234_5678)
    ev(1, 0, 0, 0, `MODE_SYSTEM);
    ev(0, 1, 0, 0, `MODE_USER);
    ev(0, 0, `CALL_PLAIN, sys_vec, `MODE_SYSTEM);
    ev(0, 0, `CALL_LONG, fw_vec, `MODE_FIRMWARE);
    for (int k = 0; k < 3; k++) begin
      ev(0, 0, k[1:0], spec_sys, `MODE_SYSTEM);
      ev(0, 0, k[1:0], spec_user, `MODE_USER);
    end
    ev(0, 0, `CALL_PLAIN, spec_sys, `MODE_USER);
    ev(1, 0, 0, 0, `MODE_SYSTEM);
    wr(`ADDR_FEAT_TEMP, 32'h0000_000c, 0);
    repeat (2) @(posedge pclk);
    `CHK({pk_en, aes_en, coprocessor_ram_limit_en, nvm_limit_en}, 4'hc)
    wr(`ADDR_FEAT_PERM, 32'h0000_00f5, 0);
    // Locked rewrite is a permitted access that simply leaves locked bits alone
    apb(`ADDR_FEAT_PERM, 1, 32'h0000_00fa, dr, de);
    `CHK(de, 1'b0)
    rd(`ADDR_FEAT_PERM, 32'h0000_00f5, 0);
    `CHK({pk_en, aes_en, coprocessor_ram_limit_en, nvm_limit_en}, 4'h5)
    do_reset;
    `CHK(seg_table_base, `SEG_BASE_RST)
    rd(`ADDR_FEAT_PERM, 32'h0000_0000, 0);
    rd(`ADDR_STATUS, 32'h0000_0300, 0);
    report_and_stop;
  end
  initial begin
    repeat (4000) @(posedge pclk);
    fail_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
